/* File: design/clk_div_pkg.sv */
// Constants and carriers shared by the machine cycle clock divider
package clk_div_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W            = 12;
  localparam int unsigned DATA_W            = 32;
  localparam logic [7:0]  CLOCK_CONFIG_IDX  = 8'h8f;
  localparam logic [11:0] CLOCK_CONFIG_ADDR = {2'h0, CLOCK_CONFIG_IDX, 2'h0};
  localparam int unsigned DSS_BIT           = 0;
  localparam logic        DSS_RESET         = 1'h0;
  localparam logic [6:0]  RSVD_READ         = 7'h00;
  localparam logic [23:0] UPPER_READ        = 24'h000000;
  localparam logic [31:0] UNMAPPED_READ     = 32'h00000000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned HALF_DIV          = 2;
  localparam int unsigned CORE_TICKS_PER_MC = 6;
  localparam int unsigned STD_MC_PCLK       = CORE_TICKS_PER_MC * HALF_DIV;
  localparam int unsigned X2_MC_PCLK        = CORE_TICKS_PER_MC;
  localparam int unsigned RST_HOLD_MC       = 2;
  localparam int unsigned WDT_RST_MC        = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic x2_active;
    logic half_rise;
    logic core_clk_en;
    logic mc_pulse;
  } clk_status_t;

  typedef struct packed {
    logic level;
    logic drive_en;
    logic sys_rst;
    logic wdt_active;
  } rst_status_t;

endpackage : clk_div_pkg

/* File: design/clk_phase_gen.sv */
// Half-rate divider, glitch-free mode switch and machine cycle strobe
`timescale 1ns/100ps
module clk_phase_gen #(
  parameter int unsigned TICKS = clk_div_pkg::CORE_TICKS_PER_MC
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Mode request
  input  wire logic                     x2_req,
  // Enables and mode
  output clk_div_pkg::clk_status_t      status
);

  logic       half_phase_reg;
  logic       x2_reg;
  logic       x2_next;
  logic       en_next;
  logic [2:0] tick_reg;
  logic [2:0] tick_next;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Mode taken at half-rate rise
  assign x2_next   = half_phase_reg ? x2_reg : x2_req;
  assign en_next   = x2_next | ~half_phase_reg;
  assign tick_next = (tick_reg == 3'(TICKS - 1)) ? 3'h0 : tick_reg + 3'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase_reg <= 1'b0;
    end else begin
      half_phase_reg <= ~half_phase_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x2_reg           <= 1'b0;
      status.x2_active <= 1'b0;
      status.half_rise <= 1'b0;
    end else begin
      x2_reg           <= x2_next;
      status.x2_active <= x2_next;
      status.half_rise <= ~half_phase_reg;
    end
  end

  // Six core ticks per machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg           <= 3'h0;
      status.core_clk_en <= 1'b0;
      status.mc_pulse    <= 1'b0;
    end else begin
      status.core_clk_en <= en_next;
      status.mc_pulse    <= en_next && (tick_reg == 3'(TICKS - 1));
      if (en_next) begin
        tick_reg <= tick_next;
      end
    end
  end

endmodule : clk_phase_gen

/* File: design/reset_pin_ctrl.sv */
// Reset pin qualifier and watchdog reset pin driver
`timescale 1ns/100ps
module reset_pin_ctrl #(
  parameter int unsigned HOLD_MC = clk_div_pkg::RST_HOLD_MC,
  parameter int unsigned WDT_MC  = clk_div_pkg::WDT_RST_MC
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Timing and events
  input  wire logic                     mc_pulse,
  input  wire logic                     wdt_timeout,
  // Pin
  input  wire logic                     rst_pin_in,
  // State
  output clk_div_pkg::rst_status_t      status
);

  logic       low_seen_reg;
  logic [1:0] hi_cnt_reg;
  logic [7:0] wdt_cnt_reg;
  logic [7:0] wdt_cnt_next;
  logic       pin_hi;
  logic       pin_rst;

  assign pin_hi  = rst_pin_in && (wdt_cnt_reg == 8'h00);
  assign pin_rst = pin_hi && (hi_cnt_reg == 2'(HOLD_MC));

  // Pin high over two full cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_seen_reg <= 1'b1;
      hi_cnt_reg   <= 2'h0;
    end else if (!pin_hi) begin
      low_seen_reg <= 1'b1;
      hi_cnt_reg   <= 2'h0;
    end else if (mc_pulse) begin
      low_seen_reg <= 1'b0;
      if (!low_seen_reg && hi_cnt_reg != 2'(HOLD_MC)) begin
        hi_cnt_reg <= hi_cnt_reg + 2'h1;
      end
    end
  end

  always_comb begin
    wdt_cnt_next = wdt_cnt_reg;
    if (wdt_timeout && wdt_cnt_reg == 8'h00) begin
      wdt_cnt_next = 8'(WDT_MC);
    end else if (mc_pulse && wdt_cnt_reg != 8'h00) begin
      wdt_cnt_next = wdt_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg       <= 8'h00;
      status.level      <= 1'b0;
      status.drive_en   <= 1'b0;
      status.wdt_active <= 1'b0;
      status.sys_rst    <= 1'b0;
    end else begin
      wdt_cnt_reg       <= wdt_cnt_next;
      status.level      <= wdt_cnt_next != 8'h00;
      status.drive_en   <= wdt_cnt_next != 8'h00;
      status.wdt_active <= wdt_cnt_next != 8'h00;
      status.sys_rst    <= pin_rst || (wdt_cnt_next != 8'h00);
    end
  end

endmodule : reset_pin_ctrl

/* File: design/machine_cycle_clock_divider.sv */
// Machine cycle clock divider with clock_config register on APB
`timescale 1ns/100ps

// Function
// - Divide-by-two stage, bypassed by software
// - Divided clock drives core and peripherals
// - Standard mode: twelve input clocks per cycle
// - Double speed: six input clocks per cycle
// - Mode change only on half-rate rise
// - Select bit is bit 0 of clock_config
// - Select bit clears on reset
// - Reserved bits unspecified, software writes zero
// - Pin high two machine cycles resets
// - Watchdog reset drives pin as output
module machine_cycle_clock_divider #(
  parameter int unsigned WDT_MC = clk_div_pkg::WDT_RST_MC
) (
  // Clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [clk_div_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [clk_div_pkg::DATA_W-1:0]    pwdata,
  output logic      [clk_div_pkg::DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Core timing
  output logic                                   core_clk_en,
  output logic                                   mc_pulse,
  output logic                                   x2_active,
  output logic                                   half_rise,
  // Reset pin and system reset
  input  wire logic                              rst_pin_in,
  output logic                                   rst_pin_out,
  output logic                                   rst_pin_oe,
  input  wire logic                              wdt_timeout,
  output logic                                   sys_rst
);

  clk_div_pkg::clk_status_t clk_status;
  clk_div_pkg::rst_status_t rst_status;
  logic                     double_speed_select_reg;
  logic                     hit;
  logic                     setup;
  logic                     wr_access;
  logic [31:0]              rd_value;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign hit       = paddr == clk_div_pkg::CLOCK_CONFIG_ADDR;
  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && hit;
  assign pready    = 1'b1;

  assign rd_value  = hit ? {clk_div_pkg::UPPER_READ, clk_div_pkg::RSVD_READ,
                            double_speed_select_reg}
                         : clk_div_pkg::UNMAPPED_READ;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= clk_div_pkg::UNMAPPED_READ;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? clk_div_pkg::UNMAPPED_READ : rd_value;
      pslverr <= !hit;
    end
  end

  // ----------------------------------------------------------------
  // Clock configuration register
  // ----------------------------------------------------------------
  // Select bit at bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_speed_select_reg <= clk_div_pkg::DSS_RESET;
    end else if (rst_status.sys_rst) begin
      double_speed_select_reg <= clk_div_pkg::DSS_RESET;
    end else if (wr_access) begin
      double_speed_select_reg <= pwdata[clk_div_pkg::DSS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Clock phase generator
  // ----------------------------------------------------------------
  // Bypass through the select bit
  clk_phase_gen #(
    .TICKS   (clk_div_pkg::CORE_TICKS_PER_MC)
  ) u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .x2_req  (double_speed_select_reg),
    .status  (clk_status)
  );

  assign core_clk_en = clk_status.core_clk_en;
  assign mc_pulse    = clk_status.mc_pulse;
  assign x2_active   = clk_status.x2_active;
  assign half_rise   = clk_status.half_rise;

  // ----------------------------------------------------------------
  // Reset pin control
  // ----------------------------------------------------------------
  reset_pin_ctrl #(
    .HOLD_MC     (clk_div_pkg::RST_HOLD_MC),
    .WDT_MC      (WDT_MC)
  ) u_rst (
    .pclk        (pclk),
    .presetn     (presetn),
    .mc_pulse    (clk_status.mc_pulse),
    .wdt_timeout (wdt_timeout),
    .rst_pin_in  (rst_pin_in),
    .status      (rst_status)
  );

  assign rst_pin_out = rst_status.level;
  assign rst_pin_oe  = rst_status.drive_en;
  assign sys_rst     = rst_status.sys_rst;

  // ----------------------------------------------------------------
  // Checker helpers
  // ----------------------------------------------------------------
  logic [3:0] since_mc_reg;
  logic       mode_moved_reg;
  logic [2:0] hi_mc_reg;
  logic       low_in_mc_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_mc_reg   <= 4'h0;
      mode_moved_reg <= 1'b1;
    end else if (mc_pulse) begin
      since_mc_reg   <= 4'h1;
      mode_moved_reg <= 1'b0;
    end else begin
      since_mc_reg   <= (since_mc_reg == 4'hf) ? since_mc_reg : since_mc_reg + 4'h1;
      mode_moved_reg <= mode_moved_reg || (x2_active != $past(x2_active));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_mc_reg     <= 3'h0;
      low_in_mc_reg <= 1'b1;
    end else if (!rst_pin_in || rst_status.wdt_active) begin
      hi_mc_reg     <= 3'h0;
      low_in_mc_reg <= 1'b1;
    end else if (mc_pulse) begin
      low_in_mc_reg <= 1'b0;
      if (!low_in_mc_reg && hi_mc_reg != 3'h7) begin
        hi_mc_reg <= hi_mc_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    psel && penable && pwrite && hit;
  endsequence

  sequence s_cfg_read_setup;
    psel && !penable && !pwrite && hit;
  endsequence

  sequence s_wdt_start;
    wdt_timeout && !rst_status.wdt_active;
  endsequence

  a_std_half_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!x2_active && $past(!x2_active) && core_clk_en) |=> !core_clk_en
  ) else $error("core enable not halved in standard mode");

  a_std_en_phase: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!x2_active && $past(!x2_active)) |-> (core_clk_en == half_rise)
  ) else $error("core enable not on divided clock");

  a_std_mc_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mc_pulse && !mode_moved_reg && !x2_active && $past(!x2_active))
      |-> (since_mc_reg == 4'(clk_div_pkg::STD_MC_PCLK))
  ) else $error("standard machine cycle length wrong");

  a_x2_mc_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mc_pulse && !mode_moved_reg && x2_active && $past(x2_active))
      |-> (since_mc_reg == 4'(clk_div_pkg::X2_MC_PCLK))
  ) else $error("double speed machine cycle length wrong");

  a_x2_full_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    x2_active |-> core_clk_en
  ) else $error("core enable gap in double speed mode");

  // Mode moves on half-rate rise only
  a_switch_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (x2_active != $past(x2_active)) |-> half_rise
  ) else $error("mode switched off the half-rate rise");

  // Mode follows bit within two clocks
  a_switch_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($changed(double_speed_select_reg) && !rst_status.sys_rst)
      |-> ##[1:2] (x2_active == double_speed_select_reg)
  ) else $error("mode did not follow select bit");

  a_cfg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_cfg_write and (!rst_status.sys_rst))
      |=> (double_speed_select_reg == $past(pwdata[clk_div_pkg::DSS_BIT]))
  ) else $error("clock_config write not stored");

  a_cfg_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_read_setup ##1 (psel && penable)
      |-> (prdata[clk_div_pkg::DSS_BIT] == double_speed_select_reg)
  ) else $error("clock_config read wrong");

  a_rst_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    sys_rst |=> (double_speed_select_reg == clk_div_pkg::DSS_RESET)
  ) else $error("select bit not cleared by reset");

  a_rsvd_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit) |-> (prdata[31:1] == 31'h00000000)
  ) else $error("reserved bits not zero");

  // Unmapped access answers an error
  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !hit) |=> pslverr
  ) else $error("unmapped access not flagged");

  // Pin reset needs two full cycles
  a_pin_qualify: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(sys_rst) && !rst_status.wdt_active)
      |-> ($past(hi_mc_reg) >= 3'(clk_div_pkg::RST_HOLD_MC))
  ) else $error("pin reset taken too early");

  a_pin_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rst_pin_in && !rst_status.wdt_active
      && hi_mc_reg >= 3'(clk_div_pkg::RST_HOLD_MC)) |=> sys_rst
  ) else $error("pin held high without reset");

  a_wdt_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wdt_start |=> (rst_pin_oe && rst_pin_out && sys_rst)
  ) else $error("watchdog reset not driven on pin");

  a_wdt_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    rst_status.wdt_active |-> (rst_pin_oe && rst_pin_out && sys_rst)
  ) else $error("pin released during watchdog reset");

  a_wdt_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(rst_status.wdt_active) |-> (!rst_pin_oe && !rst_pin_out)
  ) else $error("pin still driven after watchdog reset");

endmodule : machine_cycle_clock_divider

/* File: tb/reset_pin_partner.sv */
// External reset circuit model: holds the reset pin high, pull-down when released
`timescale 1ns/100ps
module reset_pin_partner (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Timing from the device
  input  wire logic       mc_pulse,
  // Bench request
  input  wire logic       start,
  input  wire logic [3:0] hold_n,
  // Pin
  input  wire logic       rst_pin_out,
  input  wire logic       rst_pin_oe,
  output logic            rst_pin_in,
  output logic            busy
);
  logic       drive_reg;
  logic       done_reg;
  logic [3:0] seen_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= 1'b0;
      done_reg  <= 1'b0;
      seen_reg  <= 4'h0;
    end else if (start) begin
      drive_reg <= 1'b1;
      done_reg  <= 1'b0;
      seen_reg  <= 4'h0;
    end else if (drive_reg && done_reg) begin
      drive_reg <= 1'b0;
    end else if (drive_reg && mc_pulse) begin
      seen_reg <= seen_reg + 4'h1;
      done_reg <= (seen_reg + 4'h1 == hold_n);
    end
  end

  assign rst_pin_in = rst_pin_oe ? rst_pin_out : drive_reg;
  assign busy       = drive_reg;
endmodule : reset_pin_partner

/* File: tb/test_machine_cycle_clock_divider.sv */
// Self-checking testbench for the machine cycle clock divider
`timescale 1ns/100ps
module test_machine_cycle_clock_divider;
  localparam int unsigned WDT_N = 2;
  localparam logic [11:0] CFG   = clk_div_pkg::CLOCK_CONFIG_ADDR;
  localparam logic [11:0] BAD   = 12'h240;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h00000000;
  logic        wdt_timeout = 1'b0;
  logic        pin_start   = 1'b0;
  logic [3:0]  hold_n      = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_clk_en;
  logic        mc_pulse;
  logic        x2_active;
  logic        half_rise;
  logic        rst_pin_in;
  logic        rst_pin_out;
  logic        rst_pin_oe;
  logic        sys_rst;
  logic        pin_busy;
  logic        rst_seen    = 1'b0;
  int          n_errors    = 0;
  int          tests_run   = 0;
  int          cycles      = 0;

  machine_cycle_clock_divider #(.WDT_MC(WDT_N)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_clk_en(core_clk_en),
    .mc_pulse(mc_pulse), .x2_active(x2_active), .half_rise(half_rise),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .wdt_timeout(wdt_timeout), .sys_rst(sys_rst));

  reset_pin_partner pin (
    .pclk(pclk), .presetn(presetn), .mc_pulse(mc_pulse), .start(pin_start),
    .hold_n(hold_n), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .rst_pin_in(rst_pin_in), .busy(pin_busy));

  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (sys_rst === 1'b1) rst_seen = 1'b1;
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("CHECK FAILED t=%0t run timed out", $time);
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask : fail

  task automatic check_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask : check_word

  task automatic check_count(input int got, input int exp, input string msg);
    tests_run++;
    if (got != exp) fail(msg);
  endtask : check_count

  task automatic step;
    @(posedge pclk);
    #1;
  endtask : step

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    check_bit(err, exp_err, "write error flag");
  endtask : wr

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, rd, err);
    check_word(rd, exp, "read data");
    check_bit(err, exp_err, "read error flag");
  endtask : rd_check

  task automatic measure(input int period);
    int n;
    int en;
    n = 0;
    step();
    while (mc_pulse !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    n = 0;
    en = 0;
    do begin
      step();
      n++;
      if (core_clk_en === 1'b1) en++;
    end while (mc_pulse !== 1'b1 && n < 40);
    check_count(n, period, "machine cycle length");
    check_count(en, clk_div_pkg::CORE_TICKS_PER_MC, "core enables per cycle");
  endtask : measure

  task automatic switch_to(input logic m);
    int n;
    wr(CFG, {31'h00000000, m}, 1'b0);
    n = 0;
    do begin
      step();
      n++;
    end while (x2_active !== m && n < 4);
    check_bit(x2_active, m, "mode not switched");
    check_bit(half_rise, 1'b1, "switch off half-rate rise");
  endtask : switch_to

  task automatic pin_hold(input logic [3:0] n);
    int k;
    k = 0;
    rst_seen = 1'b0;
    while (mc_pulse !== 1'b1 && k < 40) begin
      step();
      k++;
    end
    @(posedge pclk);
    hold_n    <= n;
    pin_start <= 1'b1;
    @(posedge pclk);
    pin_start <= 1'b0;
    #1;
    k = 0;
    while (pin_busy === 1'b1 && k < 80) begin
      step();
      k++;
    end
    repeat (3) step();
  endtask : pin_hold

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_check(CFG, 32'h00000000, 1'b0);
    check_bit(x2_active, 1'b0, "reset mode");
    measure(12);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes;
    switch_to(1'b1);
    rd_check(CFG, 32'h00000001, 1'b0);
    measure(6);
    switch_to(1'b0);
    measure(12);
    $display("test modes done");
  endtask : t_modes

  task automatic t_unmapped;
    wr(BAD, 32'h00000001, 1'b1);
    rd_check(BAD, 32'h00000000, 1'b1);
    rd_check(CFG, 32'h00000000, 1'b0);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_pin;
    switch_to(1'b1);
    pin_hold(4'h2);
    check_bit(rst_seen, 1'b0, "short pin pulse reset");
    rd_check(CFG, 32'h00000001, 1'b0);
    pin_hold(4'h3);
    check_bit(rst_seen, 1'b1, "pin reset missing");
    check_bit(sys_rst, 1'b0, "pin reset stuck");
    rd_check(CFG, 32'h00000000, 1'b0);
    measure(12);
    $display("test pin reset done");
  endtask : t_pin

  task automatic t_wdt;
    int n;
    int pulses;
    switch_to(1'b1);
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    #1;
    check_bit(rst_pin_oe, 1'b1, "pin not driven");
    check_bit(rst_pin_in, 1'b1, "pin level low");
    check_bit(sys_rst, 1'b1, "no watchdog reset");
    n = 0;
    pulses = 0;
    while (rst_pin_oe === 1'b1 && n < 200) begin
      if (mc_pulse === 1'b1) pulses++;
      step();
      n++;
    end
    check_count(pulses, WDT_N, "watchdog reset length");
    check_bit(sys_rst, 1'b0, "reset outlasts drive");
    check_bit(rst_pin_in, 1'b0, "pin not released");
    rd_check(CFG, 32'h00000000, 1'b0);
    $display("test watchdog done");
  endtask : t_wdt

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_unmapped();
    t_pin();
    t_wdt();
    conclude();
  end
endmodule : test_machine_cycle_clock_divider
